// ===== core/dee_ctrl.sv
// Data EEPROM access and programming controller
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "dee_map.svh"

module dee_ctrl
  import dee_pkg::*;
#(
  parameter int unsigned NUM_BYTES    = 32,
  parameter int unsigned ADDR_W       = 7,
  parameter int unsigned ERASE_CYCLES = `DEE_ERASE_CYCLES,
  parameter int unsigned PROG_CYCLES  = `DEE_PROG_CYCLES
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  // Register port
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic [7:0]             reg_wdata_i,
  input  wire logic                   reg_we_i,
  input  wire logic                   reg_re_i,
  output logic      [7:0]             reg_rdata_o,
  // EEPROM area CPU access
  input  wire logic [ADDR_W-1:0]      mem_addr_i,
  input  wire logic [7:0]             mem_wdata_i,
  input  wire logic                   mem_we_i,
  input  wire logic                   mem_re_i,
  output logic      [7:0]             mem_rdata_o,
  output logic                        mem_rdata_oe_o,
  // Power modes and protection
  input  wire logic                   wait_req_i,
  input  wire logic                   halt_req_i,
  input  wire logic                   readout_protect_option_i,
  input  wire logic                   protect_remove_i,
  output logic                        wait_ack_o,
  output logic                        busy_o,
  output logic                        mass_erase_o,
  // Array side
  output logic      [ADDR_W-6:0]      arr_row_o,
  output logic      [NUM_BYTES*8-1:0] arr_wdata_o,
  output logic      [NUM_BYTES-1:0]   arr_wmask_o,
  output logic                        arr_erase_o,
  output logic                        arr_prog_o,
  output logic      [ADDR_W-1:0]      arr_raddr_o,
  input  wire logic [7:0]             arr_rdata_i
);

  localparam int unsigned IDX_W = 5;
  localparam int unsigned ROW_W = ADDR_W - IDX_W;
  localparam int unsigned CNT_W = 24;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {protect_remove_i, readout_protect_option_i, halt_req_i, wait_req_i};
      sync2_q <= sync1_q;
    end
  end
  wire wait_s   = sync2_q[0];
  wire halt_s   = sync2_q[1];
  wire prot_s   = sync2_q[2];
  wire remove_s = sync2_q[3];

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  dee_state_t        state_q;
  dee_state_t        state_d;
  logic              lat_q;
  logic              pgm_q;
  logic [ROW_W-1:0]  row_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  cnt_d;
  logic              remove_q;
  logic              mass_q;
  logic              wait_q;

  wire csr_sel   = (reg_addr_i == `DEE_CSR_OFFSET);
  wire csr_wr    = reg_we_i && csr_sel;
  wire csr_rd    = reg_re_i && csr_sel;
  wire wr_lat    = reg_wdata_i[`DEE_BIT_LAT];
  wire wr_pgm    = reg_wdata_i[`DEE_BIT_PGM];
  wire idle      = (state_q == DEE_IDLE);
  wire cyc_end   = (state_q == DEE_DONE);
  wire stop      = halt_s;
  wire frozen    = wait_q || halt_s;
  wire start     = idle && !frozen && csr_wr && wr_pgm && lat_q && !pgm_q && !prot_s;
  // Clear of mode only honoured while no cycle pending
  wire lat_clr   = csr_wr && !wr_lat && !pgm_q;
  wire lat_fall  = lat_q && (lat_clr || cyc_end || stop);
  wire latch_wr  = mem_we_i && lat_q && !pgm_q && !prot_s;
  wire lat_clear = cyc_end || lat_fall;
  wire rm_rise   = remove_s && !remove_q;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      DEE_IDLE: begin
        if (start) begin
          state_d = DEE_ERASE;
          cnt_d   = CNT_W'(ERASE_CYCLES - 1);
        end
      end
      DEE_ERASE: begin
        if (cnt_q == '0) begin
          state_d = DEE_PROG;
          cnt_d   = CNT_W'(PROG_CYCLES - 1);
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      DEE_PROG: begin
        if (cnt_q == '0) begin
          state_d = DEE_DONE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      DEE_DONE: begin
        state_d = DEE_IDLE;
      end
    endcase
    if (stop) begin
      state_d = DEE_IDLE;
      cnt_d   = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= DEE_IDLE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Control/status bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lat_q <= 1'b0;
      pgm_q <= 1'b0;
    end else if (cyc_end || stop) begin
      lat_q <= 1'b0;
      pgm_q <= 1'b0;
    end else if (csr_wr) begin
      if (start) begin
        pgm_q <= 1'b1;
      end else if (!wr_pgm && pgm_q) begin
        pgm_q <= 1'b0;
      end
      if (wr_lat && !pgm_q) begin
        lat_q <= 1'b1;
      end else if (lat_clr) begin
        lat_q <= 1'b0;
      end
    end
  end

  // Row follows the last latched write
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      row_q <= '0;
    end else if (latch_wr) begin
      row_q <= mem_addr_i[ADDR_W-1:IDX_W];
    end
  end

  // ----------------------------------------------------------------
  // Wait handling and protection removal
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wait_q   <= 1'b0;
      remove_q <= 1'b0;
      mass_q   <= 1'b0;
    end else begin
      // Running cycle finishes before wait is entered
      wait_q   <= wait_s && (idle || cyc_end) && !(start);
      remove_q <= remove_s;
      mass_q   <= rm_rise && prot_s;
    end
  end

  // ----------------------------------------------------------------
  // Latches
  // ----------------------------------------------------------------
  logic [NUM_BYTES*8-1:0] lat_data;
  logic [NUM_BYTES-1:0]   lat_used;

  dee_latches #(
    .NUM_BYTES (NUM_BYTES),
    .IDX_W     (IDX_W)
  ) u_latches (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .clear_i    (lat_clear),
    .wr_i       (latch_wr),
    .idx_i      (mem_addr_i[IDX_W-1:0]),
    .data_i     (mem_wdata_i),
    .row_data_o (lat_data),
    .row_used_o (lat_used)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Latch contents only ever reach the array, never a read path
  wire       rd_ok  = mem_re_i && !lat_q && !prot_s && !wait_q;
  wire [7:0] csr_rv = {6'b00_0000, lat_q, pgm_q};

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o    <= 8'h00;
      mem_rdata_o    <= 8'h00;
      mem_rdata_oe_o <= 1'b0;
      arr_raddr_o    <= '0;
      arr_row_o      <= '0;
      arr_wdata_o    <= '0;
      arr_wmask_o    <= '0;
      arr_erase_o    <= 1'b0;
      arr_prog_o     <= 1'b0;
      busy_o         <= 1'b0;
      wait_ack_o     <= 1'b0;
      mass_erase_o   <= 1'b0;
    end else begin
      reg_rdata_o    <= csr_rd ? csr_rv : 8'h00;
      mem_rdata_o    <= rd_ok ? arr_rdata_i : 8'h00;
      mem_rdata_oe_o <= rd_ok;
      arr_raddr_o    <= mem_addr_i;
      arr_row_o      <= row_q;
      arr_wdata_o    <= lat_data;
      arr_wmask_o    <= lat_used;
      arr_erase_o    <= (state_d == DEE_ERASE);
      arr_prog_o     <= (state_d == DEE_PROG);
      busy_o         <= !(state_d == DEE_IDLE);
      wait_ack_o     <= wait_q;
      mass_erase_o   <= mass_q;
    end
  end

endmodule

// ===== core/dee_latches.sv
// Row data latches with AND-merge on rewrite
`timescale 1ns/1ps

module dee_latches #(
  parameter int unsigned NUM_BYTES = 32,
  parameter int unsigned IDX_W     = 5
) (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  // Control
  input  wire logic                      clear_i,
  input  wire logic                      wr_i,
  input  wire logic [IDX_W-1:0]          idx_i,
  input  wire logic [7:0]                data_i,
  // Latched contents to the array only
  output logic      [NUM_BYTES*8-1:0]    row_data_o,
  output logic      [NUM_BYTES-1:0]      row_used_o
);

  logic [7:0] byte_q [NUM_BYTES];
  logic       used_q [NUM_BYTES];

  genvar g;
  generate
    for (g = 0; g < NUM_BYTES; g++) begin : g_byte
      wire hit = wr_i && (idx_i == IDX_W'(g));
      wire [7:0] merged = used_q[g] ? (byte_q[g] & data_i) : data_i;
      always_ff @(posedge clk_i) begin
        if (!rst_n_i || clear_i) begin
          byte_q[g] <= 8'hFF;
          used_q[g] <= 1'b0;
        end else if (hit) begin
          byte_q[g] <= merged;
          used_q[g] <= 1'b1;
        end
      end
      assign row_data_o[g*8 +: 8] = byte_q[g];
      assign row_used_o[g]        = used_q[g];
    end
  endgenerate

endmodule

// ===== core/dee_map.svh
// Register offsets, field positions, reset values and timing counts for the data EEPROM controller
`ifndef DEE_MAP_SVH
`define DEE_MAP_SVH

`define DEE_CSR_OFFSET     8'h30
`define DEE_CSR_RESET      8'h00
`define DEE_BIT_PGM        0
`define DEE_BIT_LAT        1
`define DEE_ERASE_TIME_US  2000
`define DEE_PROG_TIME_US   2000
`define DEE_CLK_MHZ        40
`define DEE_ERASE_CYCLES   (`DEE_ERASE_TIME_US * `DEE_CLK_MHZ)
`define DEE_PROG_CYCLES    (`DEE_PROG_TIME_US * `DEE_CLK_MHZ)

`endif

// ===== core/dee_pkg.sv
// Types shared by the data EEPROM controller
package dee_pkg;

  typedef enum logic [3:0] {
    DEE_IDLE  = 4'b0001,
    DEE_ERASE = 4'b0010,
    DEE_PROG  = 4'b0100,
    DEE_DONE  = 4'b1000
  } dee_state_t;

endpackage

// ===== test/dee_array_model.sv
// Behavioural EEPROM array: byte erase and program by row mask
`timescale 1ns/1ps
module dee_array_model (
  // Clock and read address
  input  wire logic         clk_i,
  input  wire logic [6:0]   raddr_i,
  // Program side
  input  wire logic [1:0]   row_i,
  input  wire logic [255:0] wdata_i,
  input  wire logic [31:0]  wmask_i,
  input  wire logic         erase_i,
  input  wire logic         prog_i,
  // Read data
  output logic      [7:0]   rdata_o
);
  logic [7:0] cell_q [128];
  initial foreach (cell_q[i]) cell_q[i] = 8'hFF;
  assign rdata_o = cell_q[raddr_i];
  always @(posedge clk_i) begin
    for (int b = 0; b < 32; b++) begin
      if (wmask_i[b] && erase_i) cell_q[{row_i, b[4:0]}] <= 8'hFF;
      if (wmask_i[b] && prog_i) cell_q[{row_i, b[4:0]}] <= wdata_i[b*8+:8];
    end
  end
endmodule

// ===== test/dee_ctrl_asserts.sv
// Port-level assertions for the data EEPROM controller
`timescale 1ns/1ps
module dee_ctrl_asserts (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  // Observed ports
  input wire logic       reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       mem_re_i,
  input wire logic [7:0] mem_rdata_o,
  input wire logic       mem_rdata_oe_o,
  input wire logic       halt_req_i,
  input wire logic       wait_ack_o,
  input wire logic       busy_o,
  input wire logic       mass_erase_o,
  input wire logic       arr_erase_o,
  input wire logic       arr_prog_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Halt is synchronised, so give it a few cycles
  sequence s_halt_held; halt_req_i [*4]; endsequence
  sequence s_start; $rose(busy_o); endsequence
  sequence s_erase_end; $fell(arr_erase_o) ##0 busy_o; endsequence
  property p_rsvd; reg_re_i |=> reg_rdata_o[7:2] == 6'h00; endproperty
  property p_oe; mem_rdata_oe_o |-> $past(mem_re_i); endproperty
  property p_undriven; !mem_rdata_oe_o |-> mem_rdata_o == 8'h00; endproperty
  property p_start; s_start |-> arr_erase_o && !arr_prog_o; endproperty
  property p_chain; s_erase_end |-> arr_prog_o; endproperty
  property p_phase; arr_erase_o || arr_prog_o |-> busy_o; endproperty
  property p_wait; wait_ack_o |-> !arr_erase_o && !arr_prog_o; endproperty
  property p_halt; s_halt_held |=> !busy_o; endproperty
  property p_mass; mass_erase_o |=> !mass_erase_o; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
  a_oe: assert property (p_oe) else $error("read data without read");
  a_undriven: assert property (p_undriven) else $error("undriven bus not zero");
  a_start: assert property (p_start) else $error("cycle did not open with erase");
  a_chain: assert property (p_chain) else $error("program did not follow erase");
  a_phase: assert property (p_phase) else $error("array phase outside cycle");
  a_wait: assert property (p_wait) else $error("wait entered during cycle");
  a_halt: assert property (p_halt) else $error("halt did not stop cycle");
  a_mass: assert property (p_mass) else $error("mass erase not a pulse");
endmodule

bind dee_ctrl dee_ctrl_asserts u_chk (.clk_i, .rst_n_i, .reg_re_i, .reg_rdata_o, .mem_re_i,
  .mem_rdata_o, .mem_rdata_oe_o, .halt_req_i, .wait_ack_o, .busy_o, .mass_erase_o,
  .arr_erase_o, .arr_prog_o);

// ===== test/dee_ctrl_tb.sv
// Self-checking bench for the data EEPROM controller
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("ERROR %s expected %h seen %h", n, e, a); end end
module dee_ctrl_tb;
  typedef struct { logic [7:0] a, d, ra, e; } dee_row_t;
  logic clk_i = 0, rst_n_i = 0, reg_we_i = 0, reg_re_i = 0, mem_we_i = 0, mem_re_i = 0;
  logic wait_req_i = 0, halt_req_i = 0, readout_protect_option_i = 0, protect_remove_i = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, mem_wdata_i = 0, reg_rdata_o, mem_rdata_o;
  logic [7:0] arr_rdata_i;
  logic [6:0] mem_addr_i = 0, arr_raddr_o;
  logic       mem_rdata_oe_o, wait_ack_o, busy_o, mass_erase_o, arr_erase_o, arr_prog_o;
  logic [1:0] arr_row_o;
  logic [255:0] arr_wdata_o;
  logic [31:0] arr_wmask_o;
  int errors = 0, n_compared = 0;
  dee_row_t rows [5] = '{'{8'h30, 8'hFC, 8'h30, 8'h00}, '{8'h31, 8'h02, 8'h30, 8'h00},
    '{8'h30, 8'h02, 8'h30, 8'h02}, '{8'h30, 8'h02, 8'h31, 8'h00}, '{8'h30, 8'h00, 8'h30, 8'h00}};
  always #12.5 clk_i = ~clk_i;
  dee_ctrl #(.ERASE_CYCLES(4), .PROG_CYCLES(4)) uut (.*);
  dee_array_model u_arr (.clk_i, .raddr_i(mem_addr_i), .row_i(arr_row_o), .wdata_i(arr_wdata_o),
    .wmask_i(arr_wmask_o), .erase_i(arr_erase_o), .prog_i(arr_prog_o), .rdata_o(arr_rdata_i));
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic tick(int n = 1); repeat (n) @(posedge clk_i); endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1;
    tick();
    reg_we_i <= 0;
    tick();
  endtask
  task automatic rd_reg(logic [7:0] a, logic [7:0] e);
    reg_addr_i <= a;
    reg_re_i <= 1;
    tick();
    reg_re_i <= 0;
    #1 `CHK("csr", e, reg_rdata_o)
    tick();
  endtask
  task automatic mem_wr(logic [6:0] a, logic [7:0] d);
    mem_addr_i <= a;
    mem_wdata_i <= d;
    mem_we_i <= 1;
    tick();
    mem_we_i <= 0;
    tick();
  endtask
  task automatic mem_rd(logic [6:0] a, logic oe, logic [7:0] d);
    mem_addr_i <= a;
    mem_re_i <= 1;
    tick();
    mem_re_i <= 0;
    #1 `CHK("read enable", oe, mem_rdata_oe_o)
    `CHK("array address", a, arr_raddr_o)
    if (oe) `CHK("read data", d, mem_rdata_o)
    tick();
  endtask
  task automatic wait_lvl(ref logic s, input logic v, input string n);
    for (int i = 0; i < 40; i++) begin
      tick();
      #1;
      if (s === v) begin
        `CHK(n, v, s)
        return;
      end
    end
    $display("ERROR %s expected %h seen timeout", n, v);
    errors++;
    tally_and_finish();
  endtask
  // Stimulus never clears program start mid-cycle and never runs code from the array
  task automatic cycle(logic [6:0] a, logic [7:0] d);
    wr_reg(8'h30, 8'h02);
    mem_wr(a, d);
    wr_reg(8'h30, 8'h03);
  endtask
  initial begin
    tick(20);
    rst_n_i <= 1;
    tick();
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].ra, rows[i].e);
    end
    $display("test register table done");
    mem_wr(7'h05, 8'h00);
    wr_reg(8'h30, 8'h02);
    mem_rd(7'h23, 1'b0, 8'h00);
    mem_wr(7'h23, 8'h3C);
    mem_wr(7'h23, 8'hF0);
    mem_wr(7'h3F, 8'h5A);
    wr_reg(8'h30, 8'h03);
    rd_reg(8'h30, 8'h03);
    wr_reg(8'h30, 8'h01);
    rd_reg(8'h30, 8'h03);
    wait_lvl(busy_o, 1'b0, "busy");
    rd_reg(8'h30, 8'h00);
    mem_rd(7'h23, 1'b1, 8'h30);
    mem_rd(7'h3F, 1'b1, 8'h5A);
    mem_rd(7'h25, 1'b1, 8'hFF);
    $display("test program cycle done");
    wr_reg(8'h30, 8'h02);
    mem_wr(7'h40, 8'h00);
    wr_reg(8'h30, 8'h00);
    cycle(7'h41, 8'h77);
    wait_lvl(busy_o, 1'b0, "busy");
    mem_rd(7'h40, 1'b1, 8'hFF);
    mem_rd(7'h41, 1'b1, 8'h77);
    $display("test latch clear done");
    cycle(7'h60, 8'h11);
    wait_req_i <= 1;
    wait_lvl(wait_ack_o, 1'b1, "wait ack");
    wait_req_i <= 0;
    tick(4);
    mem_rd(7'h60, 1'b1, 8'h11);
    cycle(7'h61, 8'h22);
    halt_req_i <= 1;
    wait_lvl(busy_o, 1'b0, "halt busy");
    halt_req_i <= 0;
    tick(4);
    rd_reg(8'h30, 8'h00);
    cycle(7'h62, 8'h33);
    rst_n_i <= 0;
    tick(2);
    rst_n_i <= 1;
    tick();
    rd_reg(8'h30, 8'h00);
    $display("test wait halt reset done");
    readout_protect_option_i <= 1;
    tick(4);
    mem_rd(7'h41, 1'b0, 8'h00);
    cycle(7'h41, 8'h00);
    #1 `CHK("protected busy", 1'b0, busy_o)
    protect_remove_i <= 1;
    wait_lvl(mass_erase_o, 1'b1, "mass erase");
    $display("test protection done");
    tally_and_finish();
  end
endmodule
